/* bench/test_flash_secure_region_crc_config.sv */
// Purpose: Self-checking bench for the secure range, unlock key and flash CRC registers
// Assumes: Two flash words per sector so that CRC walks stay short
// Notes:   The flash stand-in acks after a random delay and checks the word order
`default_nettype none

module test_flash_secure_region_crc_config;
    timeunit 1ns;
    timeprecision 1ps;
    import fsc_pkg::*;

    localparam int SW  = 1;
    localparam int WPS = 1 << SW;
    // Awkward ranges: top sector with no data, invalid data start, single sector, end below start
    localparam fsc_range_t CORNERS [4] = '{'{10'd511, 11'h7ff, 11'd0}, '{10'd5, 11'h000, 11'd3},
                                           '{10'd9, 11'd1, 11'd9}, '{10'd2, 11'd7, 11'd3}};

    logic               mclk;
    logic               rst;
    fsc_bus_req_t       bus_req;
    logic [31:0]        bus_rdata;
    logic               flash_req;
    logic [12+SW-1:0]   flash_addr;
    logic               flash_ack;
    logic [31:0]        flash_rdata;
    fsc_range_t         lib_range;
    logic               lib_enabled;
    logic               lib_has_data;
    integer             seed = 32'h13e6;
    int                 miscompares = 0;
    int                 compares = 0;
    int                 acks = 0;
    logic [31:0]        exp_addr = 32'h0;
    logic [31:0]        last_crc = 32'h0;
    logic [31:0]        rd_val;
    logic               unlocked;
    fsc_range_t         cur;
    fsc_range_t         nxt;

    fsc_flash_secure_cfg #(.SW_LOG2(SW)) fsc_flash_secure_cfg_inst (
        .mclk         (mclk),
        .rst          (rst),
        .bus_req      (bus_req),
        .bus_rdata    (bus_rdata),
        .flash_req    (flash_req),
        .flash_addr   (flash_addr),
        .flash_ack    (flash_ack),
        .flash_rdata  (flash_rdata),
        .lib_range    (lib_range),
        .lib_enabled  (lib_enabled),
        .lib_has_data (lib_has_data)
    );

    // Free-running 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Flash word contents, scrambled from the address
    function automatic logic [31:0] fdata(input logic [31:0] a);
        return {a[15:0], ~a[15:0]} ^ 32'h5a3c9e17;
    endfunction

    // Reference CRC over a sector span, MSB first, no reflection
    function automatic logic [31:0] crc_ref(input logic [11:0] s, input logic [11:0] n);
        logic [31:0] c;
        logic [31:0] d;
        c = FSC_CRC_INIT;
        for (int a = int'(s) * WPS; a < (int'(s) + int'(n)) * WPS; a++) begin
            d = fdata(32'(a));
            for (int i = 31; i >= 0; i--) begin
                c = (c[31] ^ d[i]) ? ((c << 1) ^ FSC_CRC_POLY) : (c << 1);
            end
        end
        return c;
    endfunction

    // Flash stand-in: random ack delay, data scrambled while not acking
    always @(posedge mclk) begin
        if (flash_req && flash_ack) begin
            check("flash_addr", 32'(flash_addr), exp_addr);
            exp_addr <= exp_addr + 32'h1;
            acks <= acks + 1;
        end
        if (flash_req && !flash_ack && ($random(seed) & 1)) begin
            flash_ack   <= 1'b1;
            flash_rdata <= fdata(32'(flash_addr));
        end else begin
            flash_ack   <= 1'b0;
            flash_rdata <= ~flash_rdata;
        end
    end

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        d = bus_rdata;
    endtask

    task automatic chk_misc;
        logic [31:0] e;
        e = 32'h0;
        e[FSC_UNLOCKED_POS] = unlocked;
        e[FSC_ENABLED_POS] = (cur.data_start != FSC_DSS_INVALID);
        bus_rd(FSC_OFS_MISC_STATUS, rd_val);
        check("misc_status", rd_val & 32'h304, e);
    endtask

    task automatic range_try(input fsc_range_t r);
        if (unlocked && r.end_sector >= r.start_sector) cur = r;
        bus_wr(FSC_OFS_RANGE, r);
        bus_rd(FSC_OFS_RANGE, rd_val);
        check("range_read", rd_val, 32'h0);
        check("lib_range", lib_range, cur);
        bus_rd(FSC_OFS_RANGE_STATUS, rd_val);
        check("range_status", rd_val, cur);
        check("lib_enabled", {31'h0, lib_enabled}, {31'h0, cur.data_start != FSC_DSS_INVALID});
        check("lib_has_data", {31'h0, lib_has_data},
              {31'h0, cur.data_start != FSC_DSS_INVALID && cur.data_start != FSC_DSS_NO_DATA});
        chk_misc();
    endtask

    task automatic crc_run(input logic [11:0] s, input logic [11:0] n, input logic go, input int pre = 0);
        int w;
        exp_addr = 32'(s - 12'(pre)) * WPS;
        acks = 0;
        if (go) last_crc = crc_ref(s, n);
        // Optional earlier span, still walking when the main launch lands
        if (pre != 0) bus_wr(FSC_OFS_CRC_CTRL, {1'b1, 7'h0, 12'(pre), s - 12'(pre)});
        bus_wr(FSC_OFS_CRC_CTRL, {go, 7'h0, n, s});
        bus_rd(FSC_OFS_CRC_CTRL, rd_val);
        check("ctrl_read", rd_val, 32'h0);
        w = 0;
        do begin
            bus_rd(FSC_OFS_MISC_STATUS, rd_val);
            w++;
        end while (rd_val[FSC_CRC_BUSY_POS] !== 1'b0 && w < 2000);
        check("crc_busy", {31'h0, rd_val[FSC_CRC_BUSY_POS]}, 32'h0);
        repeat (4) @(posedge mclk);
        #1;
        check("flash_req_idle", {31'h0, flash_req}, 32'h0);
        check("ack_count", 32'(acks), 32'(((go ? int'(n) : 0) + pre) * WPS));
        bus_rd(FSC_OFS_CRC_RESULT, rd_val);
        check("crc_result", rd_val, last_crc);
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        wrap_up();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        bus_req = '0;
        flash_ack = 1'b0;
        flash_rdata = 32'h0;
        cur = '0;
        unlocked = 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int o = 0; o <= 32'h18; o += 4) begin
            bus_rd(8'(o), rd_val);
            check("reset_read", rd_val, 32'h0);
        end
        range_try(CORNERS[1]);
        bus_wr(FSC_OFS_UNLOCK, FSC_UNLOCK_KEY ^ 32'h00010000);
        chk_misc();
        range_try(CORNERS[2]);
        bus_wr(FSC_OFS_UNLOCK, FSC_UNLOCK_KEY);
        unlocked = 1'b1;
        bus_rd(FSC_OFS_UNLOCK, rd_val);
        check("unlock_read", rd_val, 32'h0);
        chk_misc();
        for (int k = 0; k < 4; k++) range_try(CORNERS[k]);
        for (int k = 0; k < 12; k++) begin
            nxt.start_sector = 11'($random(seed) & 32'h1ff);
            nxt.end_sector   = 10'($random(seed) & 32'h1ff);
            nxt.data_start   = ($random(seed) & 1) ? FSC_DSS_NO_DATA : 11'($random(seed) & 32'h1ff);
            range_try(nxt);
        end
        crc_run(12'd3, 12'd0, 1'b1);
        crc_run(12'd5, 12'd1, 1'b0);
        crc_run(12'd4095, 12'd1, 1'b1);
        crc_run(12'd0, 12'd2, 1'b1);
        crc_run(12'd3, 12'd1, 1'b1, 1);
        for (int k = 0; k < 6; k++) begin
            crc_run(12'($random(seed) & 32'hff), 12'($random(seed) & 32'h3), 1'b1);
        end
        wrap_up();
    end

endmodule // test_flash_secure_region_crc_config

`default_nettype wire

/* design/fsc_crc_engine.sv */
// Purpose: Sector-based CRC walk over main flash words
// Assumes: Flash read port answers with flash_ack and data in the same cycle
// Notes:   Zero sector count finishes at once with the seed value
`default_nettype none

module fsc_crc_engine #(
    parameter int SW_LOG2 = fsc_pkg::FSC_SECTOR_WORDS_LOG2
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  start,
    input  wire logic [11:0]           start_sector,
    input  wire logic [11:0]           sector_count,
    output logic                       busy,
    output logic                       done,
    output logic [31:0]                result,
    output logic                       flash_req,
    output logic [12+SW_LOG2-1:0]      flash_addr,
    input  wire logic                  flash_ack,
    input  wire logic [31:0]           flash_rdata
);
    import fsc_pkg::*;

    localparam int WA = 12 + SW_LOG2;

    typedef enum logic [2:0] {
        FSC_IDLE   = 3'b001,
        FSC_FETCH  = 3'b010,
        FSC_FINISH = 3'b100
    } fsc_eng_state_t;

    fsc_eng_state_t state_q;
    fsc_eng_state_t state_d;
    logic [31:0]    crc_q;
    logic [WA-1:0]  addr_q;
    logic [WA-1:0]  left_q;

    // Handshake and status outputs
    assign busy       = (state_q != FSC_IDLE);
    assign done       = (state_q == FSC_FINISH);
    assign flash_req  = (state_q == FSC_FETCH);
    assign flash_addr = addr_q;
    assign result     = crc_q;

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            FSC_IDLE: begin
                if (start) begin
                    state_d = (sector_count == 12'h000) ? FSC_FINISH : FSC_FETCH;
                end
            end
            FSC_FETCH: begin
                if (flash_ack && left_q == WA'(1)) begin
                    state_d = FSC_FINISH;
                end
            end
            FSC_FINISH: state_d = FSC_IDLE;
            default:    state_d = FSC_IDLE;
        endcase
    end

    // Walk the span, one word per acknowledge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= FSC_IDLE;
            crc_q   <= FSC_RESET_WORD;
            addr_q  <= '0;
            left_q  <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == FSC_IDLE && start) begin
                crc_q  <= FSC_CRC_INIT;
                addr_q <= {start_sector, {SW_LOG2{1'b0}}};
                left_q <= {sector_count, {SW_LOG2{1'b0}}};
            end else if (flash_req && flash_ack) begin
                crc_q  <= fsc_crc_word(crc_q, flash_rdata);
                addr_q <= addr_q + WA'(1);
                left_q <= left_q - WA'(1);
            end
        end
    end

    // A started span with sectors fetches before finishing
    property p_eng_fetch;
        @(posedge mclk) disable iff (rst)
        (state_q == FSC_IDLE && start && sector_count != 12'h000) |=> flash_req && !done;
    endproperty
    a_eng_fetch: assert property (p_eng_fetch) else $error("crc walk did not fetch");

    // Empty span finishes next cycle with the seed
    property p_eng_empty;
        @(posedge mclk) disable iff (rst)
        (state_q == FSC_IDLE && start && sector_count == 12'h000) |=> done && result == FSC_CRC_INIT;
    endproperty
    a_eng_empty: assert property (p_eng_empty) else $error("empty crc span mishandled");

endmodule // fsc_crc_engine

`default_nettype wire

/* design/fsc_flash_secure_cfg.sv */
// Purpose: Secure library range setting, unlock key and flash CRC control registers
// Assumes: Register port and flash read port run on mclk
// Notes:   Unlock stays in force until reset
// Notes on behaviour
// - End sector in bits 31:22, write-only
// - Data-start zero keeps library from starting
// - Data-start all ones means no data region
// - Start sector in bits 10:0, write-only
// - Range and unlock registers read zero
// - Range writes ignored while still locked
// - Fixed key write releases the lock
// - Control bit 31 launches a CRC check
// - Launch bit self-clears when CRC begins
// - Bits 23:12 give CRC sector count
// - Bits 11:0 give CRC first sector
// - Control register reads have no effect
// - Unlock sets status flag at bit 2
// - Status register mirrors active range fields
`default_nettype none

module fsc_flash_secure_cfg #(
    parameter int SW_LOG2 = fsc_pkg::FSC_SECTOR_WORDS_LOG2
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire fsc_pkg::fsc_bus_req_t bus_req,
    output logic [31:0]                bus_rdata,
    output logic                       flash_req,
    output logic [12+SW_LOG2-1:0]      flash_addr,
    input  wire logic                  flash_ack,
    input  wire logic [31:0]           flash_rdata,
    output var fsc_pkg::fsc_range_t    lib_range,
    output logic                       lib_enabled,
    output logic                       lib_has_data
);
    import fsc_pkg::*;

    // Register state
    fsc_range_t    range_q;
    logic          enabled_q;
    logic          unlocked_q;
    fsc_crc_ctrl_t ctrl_q;
    logic          launch_q;
    logic          launch_d;
    logic [31:0]   result_q;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;

    // Engine hookup
    logic          eng_busy;
    logic          eng_done;
    logic [31:0]   eng_result;
    logic          eng_begin;

    // Address decode
    wire           wr_range    = bus_req.wr && fsc_hit(bus_req.addr, FSC_OFS_RANGE);
    wire           wr_unlock   = bus_req.wr && fsc_hit(bus_req.addr, FSC_OFS_UNLOCK);
    wire           wr_ctrl     = bus_req.wr && fsc_hit(bus_req.addr, FSC_OFS_CRC_CTRL);
    wire           rd_result   = bus_req.rd && fsc_hit(bus_req.addr, FSC_OFS_CRC_RESULT);
    wire           rd_rstatus  = bus_req.rd && fsc_hit(bus_req.addr, FSC_OFS_RANGE_STATUS);
    wire           rd_mstatus  = bus_req.rd && fsc_hit(bus_req.addr, FSC_OFS_MISC_STATUS);

    // Candidate range fields and their checks
    wire fsc_range_t    range_cand = fsc_range_t'(bus_req.wdata);
    wire fsc_crc_ctrl_t ctrl_cand  = fsc_crc_ctrl_t'(bus_req.wdata);
    wire           order_ok    = ({1'b0, range_cand.end_sector} >= range_cand.start_sector);
    wire           range_take  = wr_range && unlocked_q && order_ok;
    wire           key_ok      = wr_unlock && (bus_req.wdata == FSC_UNLOCK_KEY);
    wire           dss_valid   = (range_cand.data_start != FSC_DSS_INVALID);

    // Launch request: a new set wins over the self-clear
    wire           launch_set  = wr_ctrl && ctrl_cand.launch;
    assign eng_begin = launch_q && !eng_busy;
    assign launch_d  = launch_set || (launch_q && !eng_begin);

    // Status words
    wire [31:0]    misc_word   = (32'(unlocked_q) << FSC_UNLOCKED_POS)
                               | (32'(enabled_q)  << FSC_ENABLED_POS)
                               | (32'(eng_busy || launch_q) << FSC_CRC_BUSY_POS);

    // Read selection: write-only registers and unmapped offsets read zero
    assign rdata_d = rd_result  ? result_q :
                     rd_rstatus ? 32'(range_q) :
                     rd_mstatus ? misc_word :
                                  FSC_RESET_WORD;

    // Active range outputs
    assign lib_range    = range_q;
    assign lib_enabled  = enabled_q;
    assign lib_has_data = enabled_q && (range_q.data_start != FSC_DSS_NO_DATA);
    assign bus_rdata    = rdata_q;

    // Lock release, sticky until reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            unlocked_q <= 1'b0;
        end else if (key_ok) begin
            unlocked_q <= 1'b1;
        end
    end

    // Range capture and library enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            range_q   <= fsc_range_t'(FSC_RESET_WORD);
            enabled_q <= 1'b0;
        end else if (range_take) begin
            range_q   <= range_cand;
            enabled_q <= dss_valid;
        end
    end

    // CRC control fields and launch bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q   <= fsc_crc_ctrl_t'(FSC_RESET_WORD);
            launch_q <= 1'b0;
        end else begin
            launch_q <= launch_d;
            if (wr_ctrl) begin
                ctrl_q <= ctrl_cand;
            end
        end
    end

    // Result capture and read data
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_q <= FSC_RESET_WORD;
            rdata_q  <= FSC_RESET_WORD;
        end else begin
            rdata_q <= rdata_d;
            if (eng_done) begin
                result_q <= eng_result;
            end
        end
    end

    // CRC walk over the selected sectors
    fsc_crc_engine #(
        .SW_LOG2      (SW_LOG2)
    ) fsc_crc_engine_inst (
        .mclk         (mclk),
        .rst          (rst),
        .start        (eng_begin),
        .start_sector (ctrl_q.start),
        .sector_count (ctrl_q.count),
        .busy         (eng_busy),
        .done         (eng_done),
        .result       (eng_result),
        .flash_req    (flash_req),
        .flash_addr   (flash_addr),
        .flash_ack    (flash_ack),
        .flash_rdata  (flash_rdata)
    );

    // Write-only registers read back zero
    property p_wo_zero;
        @(posedge mclk) disable iff (rst)
        (bus_req.rd && (fsc_hit(bus_req.addr, FSC_OFS_RANGE) || fsc_hit(bus_req.addr, FSC_OFS_UNLOCK)))
            |=> bus_rdata == 32'h00000000;
    endproperty
    a_wo_zero: assert property (p_wo_zero) else $error("write-only register read nonzero");

    // Locked range writes change nothing
    property p_locked_range;
        @(posedge mclk) disable iff (rst)
        (wr_range && !unlocked_q) |=> $stable(lib_range) && $stable(lib_enabled);
    endproperty
    a_locked_range: assert property (p_locked_range) else $error("range changed while locked");

    // Key write shows in the status word on a read soon after
    property p_unlock_flag;
        @(posedge mclk) disable iff (rst)
        (key_ok && !bus_req.rd) ##[1:8] rd_mstatus
            |=> bus_rdata[FSC_UNLOCKED_POS];
    endproperty
    a_unlock_flag: assert property (p_unlock_flag) else $error("unlock flag not shown");

    // Launch bit clears once the engine has begun
    property p_launch_clear;
        @(posedge mclk) disable iff (rst)
        (launch_q && !eng_busy && !launch_set) |=> !launch_q && eng_busy;
    endproperty
    a_launch_clear: assert property (p_launch_clear) else $error("launch bit not self-cleared");

    // Launch write reaches the engine within a bounded wait after idle
    property p_launch_start;
        @(posedge mclk) disable iff (rst)
        (launch_set && !eng_busy && !launch_q) |=> launch_q ##1 eng_busy;
    endproperty
    a_launch_start: assert property (p_launch_start) else $error("crc did not start");

    // Control reads return zero and leave launch alone
    property p_ctrl_read;
        @(posedge mclk) disable iff (rst)
        (bus_req.rd && fsc_hit(bus_req.addr, FSC_OFS_CRC_CTRL) && !launch_q && !eng_busy)
            |=> bus_rdata == 32'h00000000 && !launch_q && !eng_busy;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read had an effect");

    // Reversed range leaves the library as it was
    property p_reject_order;
        @(posedge mclk) disable iff (rst)
        (wr_range && unlocked_q && !order_ok) |=> lib_enabled == $past(lib_enabled) && $stable(lib_range);
    endproperty
    a_reject_order: assert property (p_reject_order) else $error("reversed range accepted");

    // Zero data-start keeps library disabled
    property p_dss_zero;
        @(posedge mclk) disable iff (rst)
        (range_take && range_cand.data_start == FSC_DSS_INVALID) |=> !lib_enabled && lib_range.data_start == 11'h000;
    endproperty
    a_dss_zero: assert property (p_dss_zero) else $error("library enabled with invalid data start");

    // All-ones data-start gives code region only
    property p_no_data;
        @(posedge mclk) disable iff (rst)
        (range_take && range_cand.data_start == FSC_DSS_NO_DATA) |=> lib_enabled && !lib_has_data;
    endproperty
    a_no_data: assert property (p_no_data) else $error("data region present for all-ones code");

    // Finished CRC is what the result register shows
    property p_result;
        @(posedge mclk) disable iff (rst)
        eng_done |=> result_q == $past(eng_result);
    endproperty
    a_result: assert property (p_result) else $error("crc result not captured");

    // Accepted range shows fields as written
    property p_range_fields;
        @(posedge mclk) disable iff (rst)
        range_take |=> lib_range.end_sector == $past(bus_req.wdata[31:22])
                   && lib_range.start_sector == $past(bus_req.wdata[10:0]);
    endproperty
    a_range_fields: assert property (p_range_fields) else $error("range fields misplaced");

    // Wrong key leaves a closed lock closed
    property p_wrong_key;
        @(posedge mclk) disable iff (rst)
        (wr_unlock && bus_req.wdata != FSC_UNLOCK_KEY && !unlocked_q) |=> !unlocked_q;
    endproperty
    a_wrong_key: assert property (p_wrong_key) else $error("wrong key unlocked");

    // Unlock holds until the next reset
    property p_unlock_sticky;
        @(posedge mclk) disable iff (rst)
        unlocked_q |=> unlocked_q;
    endproperty
    a_unlock_sticky: assert property (p_unlock_sticky) else $error("unlock lost before reset");

    // Status word shows the lock state of the read cycle
    property p_misc_unlock;
        @(posedge mclk) disable iff (rst)
        rd_mstatus |=> bus_rdata[FSC_UNLOCKED_POS] == $past(unlocked_q);
    endproperty
    a_misc_unlock: assert property (p_misc_unlock) else $error("unlock flag wrong in status");

    // Range status read returns the active range
    property p_range_status;
        @(posedge mclk) disable iff (rst)
        rd_rstatus |=> bus_rdata == 32'($past(lib_range));
    endproperty
    a_range_status: assert property (p_range_status) else $error("range status not mirrored");

    // Control write stores the sector count
    property p_ctrl_count;
        @(posedge mclk) disable iff (rst)
        wr_ctrl |=> ctrl_q.count == $past(bus_req.wdata[23:12]);
    endproperty
    a_ctrl_count: assert property (p_ctrl_count) else $error("crc sector count misplaced");

    // Control write stores the first sector
    property p_ctrl_start;
        @(posedge mclk) disable iff (rst)
        wr_ctrl |=> ctrl_q.start == $past(bus_req.wdata[11:0]);
    endproperty
    a_ctrl_start: assert property (p_ctrl_start) else $error("crc first sector misplaced");

    // Launch during a walk waits its turn
    property p_launch_pending;
        @(posedge mclk) disable iff (rst)
        (launch_set && eng_busy) |=> launch_q;
    endproperty
    a_launch_pending: assert property (p_launch_pending) else $error("launch lost while busy");

    // Result holds between completions
    property p_result_hold;
        @(posedge mclk) disable iff (rst)
        !eng_done |=> $stable(result_q);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("crc result changed unasked");

    // Accepted range with a valid data start enables
    property p_range_enable;
        @(posedge mclk) disable iff (rst)
        (range_take && dss_valid) |=> lib_enabled;
    endproperty
    a_range_enable: assert property (p_range_enable) else $error("valid range not enabled");

    // An enabled library never ends below its start
    property p_enabled_order;
        @(posedge mclk) disable iff (rst)
        lib_enabled |-> ({1'b0, lib_range.end_sector} >= lib_range.start_sector);
    endproperty
    a_enabled_order: assert property (p_enabled_order) else $error("enabled range reversed");

endmodule // fsc_flash_secure_cfg

`default_nettype wire

/* design/fsc_pkg.sv */
// Purpose: Shared constants, types and helpers for the flash secure range and CRC block
// Assumes: One 32-bit register per offset on the plain register port
// Notes:   Field layouts are packed structs overlaying the written word
`default_nettype none

package fsc_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0]  FSC_OFS_RANGE        = 8'h00;
    localparam logic [7:0]  FSC_OFS_UNLOCK       = 8'h04;
    localparam logic [7:0]  FSC_OFS_CRC_CTRL     = 8'h08;
    localparam logic [7:0]  FSC_OFS_CRC_RESULT   = 8'h0c;
    localparam logic [7:0]  FSC_OFS_RANGE_STATUS = 8'h10;
    localparam logic [7:0]  FSC_OFS_MISC_STATUS  = 8'h14;

    // Fixed unlock key
    localparam logic [31:0] FSC_UNLOCK_KEY       = 32'ha35f6d24;

    // Bit positions in the misc status word
    localparam int          FSC_UNLOCKED_POS     = 2;
    localparam int          FSC_ENABLED_POS      = 8;
    localparam int          FSC_CRC_BUSY_POS     = 9;

    // Special data-start codes
    localparam logic [10:0] FSC_DSS_INVALID      = 11'h000;
    localparam logic [10:0] FSC_DSS_NO_DATA      = 11'h7ff;

    // Reset, seed and polynomial values
    localparam logic [31:0] FSC_RESET_WORD       = 32'h00000000;
    localparam logic [31:0] FSC_CRC_INIT         = 32'hffffffff;
    localparam logic [31:0] FSC_CRC_POLY         = 32'h04c11db7;

    // Default log2 of words per sector
    localparam int          FSC_SECTOR_WORDS_LOG2 = 9;

    // Range-setting word layout
    typedef struct packed {
        logic [9:0]  end_sector;
        logic [10:0] data_start;
        logic [10:0] start_sector;
    } fsc_range_t;

    // CRC control word layout
    typedef struct packed {
        logic        launch;
        logic [6:0]  rsvd;
        logic [11:0] count;
        logic [11:0] start;
    } fsc_crc_ctrl_t;

    // One register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } fsc_bus_req_t;

    // Address match used by every decode
    function automatic logic fsc_hit(input logic [7:0] addr, input logic [7:0] ofs);
        fsc_hit = (addr == ofs);
    endfunction

    // One 32-bit word folded into the running CRC, MSB first
    function automatic logic [31:0] fsc_crc_word(input logic [31:0] crc, input logic [31:0] data);
        logic [31:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ data[i]) ? ((c << 1) ^ FSC_CRC_POLY) : (c << 1);
        end
        fsc_crc_word = c;
    endfunction

endpackage

`default_nettype wire
